// File: osc_host_model.sv
// Host-side model: drives oscillator-select levels, watches alarm pins.
// Assumes the bench commands the levels the host drives.
`timescale 1ns/1ps
module osc_host_model (
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic [3:0] host_drive,
	output logic [3:0] pin_in,
	output logic [3:0] alarm_seen
);
	// ======
	// Wire level: device drives outputs, host drives inputs only
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & host_drive);
	// Alarm levels seen by host
	assign alarm_seen = pin_oe & pin_out;
endmodule : osc_host_model

// File: pin_source_mux.sv
// One pin's alarm source selector, registered.
// Assumes flags are synchronous to clk.
`timescale 1ns/1ps
module pin_source_mux (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] sel,
	input wire pwr_alarm_pkg::chan_flags_s chan_a,
	input wire pwr_alarm_pkg::chan_flags_s chan_b,
	output logic alarm
);
	logic [17:0] sources;
	logic alarm_next;

	// Flat list: channel A codes 0..8, channel B codes 9..17
	assign sources = {chan_b, chan_a};

	// Out-of-range codes drive low
	always_comb
	begin
		alarm_next = 1'b0;
		if (sel <= pwr_alarm_pkg::SRC_LAST)
		begin
			alarm_next = sources[sel[4:0]];
		end
	end

	// Registered pin value
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			alarm <= 1'b0;
		end
		else
		begin
			alarm <= alarm_next;
		end
	end
endmodule : pin_source_mux

// File: power_detect_alarm_pin_config.sv
// Power detector configuration registers, threshold compare, pin routing.
// Assumes single-cycle register port and power samples synchronous to clk.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module power_detect_alarm_pin_config (
	input wire logic clk,
	input wire logic sys_rst,
	input wire pwr_alarm_pkg::reg_req_s req,
	output logic [7:0] rdata,
	input wire logic [15:0] avg_power,
	input wire logic avg_power_valid,
	input wire pwr_alarm_pkg::chan_flags_s chan_a_flags,
	input wire pwr_alarm_pkg::chan_flags_s chan_b_flags,
	input wire logic [3:0] pin_in,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe,
	output logic [1:0] osc_select,
	output logic osc_select_invalid,
	output logic gain_control_run,
	output logic [1:0] power_cmp_a,
	output logic irq
);
	localparam int IRQ_W_L = pwr_alarm_pkg::IRQ_W;
	logic [15:0] power_high_threshold_reg;
	logic [15:0] power_low_threshold_reg;
	logic power_compare_two_bit_enable_reg;
	logic gain_control_reset_bit_reg;
	logic [3:0] pin_direction_bits_reg;
	logic [1:0] osc_route1_reg;
	logic [1:0] osc_route0_reg;
	logic [7:0] pin_output_source_select_reg [4];
	logic [IRQ_W_L-1:0] irq_status_reg;
	logic [IRQ_W_L-1:0] irq_enable_reg;
	logic [1:0] power_flag_reg;
	pwr_alarm_pkg::gain_state_e gain_state_reg;
	logic [7:0] rdata_next;
	logic [3:0] pin_alarm;
	logic osc_bit1;
	logic osc_bit0;
	logic [IRQ_W_L-1:0] irq_event;
	logic [IRQ_W_L-1:0] irq_clear;
	logic above_high;
	logic below_low;
	pwr_alarm_pkg::chan_flags_s chan_a_live;

	function automatic logic route_pick(input logic [1:0] route, input logic [3:0] pins);
		logic bit_val;
		bit_val = pins[3];
		case (route)
			pwr_alarm_pkg::ROUTE_PIN4: bit_val = pins[3];
			pwr_alarm_pkg::ROUTE_PIN1: bit_val = pins[0];
			pwr_alarm_pkg::ROUTE_PIN3: bit_val = pins[2];
			pwr_alarm_pkg::ROUTE_PIN2: bit_val = pins[1];
			default: bit_val = pins[3];
		endcase
		return bit_val;
	endfunction : route_pick

	// ==========================================================
	// Register writes
	// Thresholds, one byte lane per address
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			power_high_threshold_reg <= pwr_alarm_pkg::THRESH_RESET;
			power_low_threshold_reg <= pwr_alarm_pkg::THRESH_RESET;
		end
		else if (req.wr)
		begin
			if (req.addr == pwr_alarm_pkg::ADDR_PWR_HIGH_LO)
				power_high_threshold_reg[7:0] <= req.wdata;
			else if (req.addr == pwr_alarm_pkg::ADDR_PWR_HIGH_HI)
				power_high_threshold_reg[15:8] <= req.wdata;
			else if (req.addr == pwr_alarm_pkg::ADDR_PWR_LOW_LO)
				power_low_threshold_reg[7:0] <= req.wdata;
			else if (req.addr == pwr_alarm_pkg::ADDR_PWR_LOW_HI)
				power_low_threshold_reg[15:8] <= req.wdata;
		end
	end

	// Format, gain reset, direction and routing fields; reserved bits dropped
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			power_compare_two_bit_enable_reg <= 1'b0;
			gain_control_reset_bit_reg <= 1'b0;
			pin_direction_bits_reg <= 4'h0;
			osc_route1_reg <= 2'b00;
			osc_route0_reg <= 2'b00;
		end
		else if (req.wr)
		begin
			if (req.addr == pwr_alarm_pkg::ADDR_CMP_FORMAT)
				power_compare_two_bit_enable_reg <= req.wdata[pwr_alarm_pkg::FORMAT_BIT];
			else if (req.addr == pwr_alarm_pkg::ADDR_GAIN_RESET)
				gain_control_reset_bit_reg <= req.wdata[pwr_alarm_pkg::GAIN_RESET_BIT];
			else if (req.addr == pwr_alarm_pkg::ADDR_PIN_DIR)
				pin_direction_bits_reg <= req.wdata[3:0];
			else if (req.addr == pwr_alarm_pkg::ADDR_OSC_ROUTE)
			begin
				osc_route1_reg <= req.wdata[pwr_alarm_pkg::ROUTE1_LSB +: 2];
				osc_route0_reg <= req.wdata[pwr_alarm_pkg::ROUTE0_LSB +: 2];
			end
		end
	end

	// Per-pin source select registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < 4; i++)
				pin_output_source_select_reg[i] <= pwr_alarm_pkg::REG_RESET;
		end
		else if (req.wr)
		begin
			if (req.addr == pwr_alarm_pkg::ADDR_PIN1_SEL)
				pin_output_source_select_reg[0] <= req.wdata;
			else if (req.addr == pwr_alarm_pkg::ADDR_PIN2_SEL)
				pin_output_source_select_reg[1] <= req.wdata;
			else if (req.addr == pwr_alarm_pkg::ADDR_PIN3_SEL)
				pin_output_source_select_reg[2] <= req.wdata;
			else if (req.addr == pwr_alarm_pkg::ADDR_PIN4_SEL)
				pin_output_source_select_reg[3] <= req.wdata;
		end
	end

	// ==========================================================
	// Gain-control reset sequencing
	// Held while the bit is one, runs after it returns to zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			gain_state_reg <= pwr_alarm_pkg::GAIN_HELD;
			gain_control_run <= 1'b0;
		end
		else
		begin
			case (gain_state_reg)
				pwr_alarm_pkg::GAIN_HELD:
				begin
					gain_control_run <= 1'b0;
					if (!gain_control_reset_bit_reg)
					begin
						gain_state_reg <= pwr_alarm_pkg::GAIN_RUN;
						gain_control_run <= 1'b1;
					end
				end
				pwr_alarm_pkg::GAIN_RUN:
				begin
					if (gain_control_reset_bit_reg)
					begin
						gain_state_reg <= pwr_alarm_pkg::GAIN_HELD;
						gain_control_run <= 1'b0;
					end
				end
				default:
				begin
					gain_state_reg <= pwr_alarm_pkg::GAIN_HELD;
					gain_control_run <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Threshold compare
	assign above_high = avg_power > power_high_threshold_reg;
	assign below_low = avg_power < power_low_threshold_reg;

	// Power flags; bit 1 used only in two-bit format
	always_ff @(posedge clk)
	begin
		if (sys_rst || !gain_control_run)
		begin
			power_flag_reg <= 2'b00;
			power_cmp_a <= 2'b00;
		end
		else if (avg_power_valid)
		begin
			if (power_compare_two_bit_enable_reg)
			begin
				power_flag_reg <= {below_low, above_high};
				power_cmp_a <= {below_low, above_high};
			end
			else
			begin
				power_flag_reg <= {1'b0, above_high};
				power_cmp_a <= {1'b0, above_high};
			end
		end
	end

	// Channel A power flags come from this comparator
	always_comb
	begin
		chan_a_live = chan_a_flags;
		chan_a_live.power_flag = power_flag_reg;
	end

	// ==========================================================
	// Pin alarm sources
	for (genvar p = 0; p < 4; p++)
	begin : g_pin
		pin_source_mux u_mux (
			.clk(clk),
			.sys_rst(sys_rst),
			.sel(pin_output_source_select_reg[p]),
			.chan_a(chan_a_live),
			.chan_b(chan_b_flags),
			.alarm(pin_alarm[p])
		);
	end

	// Pin drive: enable only for output-direction pins
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pin_out <= 4'h0;
			pin_oe <= 4'h0;
		end
		else
		begin
			pin_oe <= pin_direction_bits_reg;
			pin_out <= pin_alarm & pin_direction_bits_reg;
		end
	end

	// ==========================================================
	// Oscillator selection from input pins
	assign osc_bit1 = route_pick(osc_route1_reg, pin_in & ~pin_direction_bits_reg);
	assign osc_bit0 = route_pick(osc_route0_reg, pin_in & ~pin_direction_bits_reg);

	// Forbidden code 11 keeps the previous choice
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			osc_select <= pwr_alarm_pkg::OSC_ONE;
			osc_select_invalid <= 1'b0;
		end
		else
		begin
			osc_select_invalid <= osc_bit1 & osc_bit0;
			if (!(osc_bit1 & osc_bit0))
				osc_select <= {osc_bit1, osc_bit0};
		end
	end

	// ==========================================================
	// Interrupts: sticky status, write-one clear, enable
	assign irq_event = {osc_bit1 & osc_bit0,
		gain_control_run & avg_power_valid & below_low,
		gain_control_run & avg_power_valid & above_high};
	assign irq_clear = (req.wr && req.addr == pwr_alarm_pkg::ADDR_IRQ_CLEAR) ?
		req.wdata[IRQ_W_L-1:0] : '0;

	// Set wins over clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			irq_status_reg <= '0;
			irq_enable_reg <= '0;
			irq <= 1'b0;
		end
		else
		begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
			if (req.wr && req.addr == pwr_alarm_pkg::ADDR_IRQ_ENABLE)
				irq_enable_reg <= req.wdata[IRQ_W_L-1:0];
			irq <= |(((irq_status_reg & ~irq_clear) | irq_event) &
				((req.wr && req.addr == pwr_alarm_pkg::ADDR_IRQ_ENABLE) ?
				req.wdata[IRQ_W_L-1:0] : irq_enable_reg));
		end
	end

	// ==========================================================
	// Read decode; reserved bits read zero
	always_comb
	begin
		rdata_next = pwr_alarm_pkg::READ_ZERO;
		if (req.addr == pwr_alarm_pkg::ADDR_PWR_HIGH_LO)
			rdata_next = power_high_threshold_reg[7:0];
		else if (req.addr == pwr_alarm_pkg::ADDR_PWR_HIGH_HI)
			rdata_next = power_high_threshold_reg[15:8];
		else if (req.addr == pwr_alarm_pkg::ADDR_PWR_LOW_LO)
			rdata_next = power_low_threshold_reg[7:0];
		else if (req.addr == pwr_alarm_pkg::ADDR_PWR_LOW_HI)
			rdata_next = power_low_threshold_reg[15:8];
		else if (req.addr == pwr_alarm_pkg::ADDR_CMP_FORMAT)
			rdata_next = {7'h00, power_compare_two_bit_enable_reg};
		else if (req.addr == pwr_alarm_pkg::ADDR_GAIN_RESET)
			rdata_next = {3'h0, gain_control_reset_bit_reg, 4'h0};
		else if (req.addr == pwr_alarm_pkg::ADDR_PIN1_SEL)
			rdata_next = pin_output_source_select_reg[0];
		else if (req.addr == pwr_alarm_pkg::ADDR_PIN2_SEL)
			rdata_next = pin_output_source_select_reg[1];
		else if (req.addr == pwr_alarm_pkg::ADDR_PIN3_SEL)
			rdata_next = pin_output_source_select_reg[2];
		else if (req.addr == pwr_alarm_pkg::ADDR_PIN4_SEL)
			rdata_next = pin_output_source_select_reg[3];
		else if (req.addr == pwr_alarm_pkg::ADDR_PIN_DIR)
			rdata_next = {4'h0, pin_direction_bits_reg};
		else if (req.addr == pwr_alarm_pkg::ADDR_OSC_ROUTE)
			rdata_next = {2'b00, osc_route1_reg, 2'b00, osc_route0_reg};
		else if (req.addr == pwr_alarm_pkg::ADDR_IRQ_STATUS)
			rdata_next = {5'h00, irq_status_reg};
		else if (req.addr == pwr_alarm_pkg::ADDR_IRQ_ENABLE)
			rdata_next = {5'h00, irq_enable_reg};
		else if (req.addr == pwr_alarm_pkg::ADDR_STATE)
			rdata_next = {3'h0, osc_select_invalid, osc_select, power_flag_reg};
	end

	// Read data registered, valid in cycle after strobe only
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rdata <= 8'h00;
		else if (req.rd)
			rdata <= rdata_next;
		else
			rdata <= 8'h00;
	end
endmodule : power_detect_alarm_pin_config

// File: pwr_alarm_monitor.sv
// Port checker for the power detector configuration slice.
// Assumes one clock domain and synchronous active-high reset.
`timescale 1ns/1ps
module pwr_alarm_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire pwr_alarm_pkg::reg_req_s req,
	input wire logic [7:0] rdata,
	input wire logic avg_power_valid,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic [1:0] osc_select,
	input wire logic osc_select_invalid,
	input wire logic gain_control_run,
	input wire logic [1:0] power_cmp_a,
	input wire logic irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ======
	// Register port
	a_rdata_idle_zero: assert property (!$past(req.rd) |-> rdata == 8'h00)
		else $error("rdata not zero outside read slot");
	a_dir_write_oe: assert property (req.wr && req.addr == 10'h037 |-> ##2 pin_oe == $past(req.wdata[3:0], 2))
		else $error("pin_oe does not follow direction write");

	// ======
	// Pins and oscillator choice
	a_input_pin_quiet: assert property ((pin_out & ~pin_oe) == 4'h0)
		else $error("pin_out high on an input pin");
	a_osc_code_legal: assert property (osc_select != 2'b11)
		else $error("oscillator select shows none");
	a_osc_hold_invalid: assert property (osc_select_invalid |-> $stable(osc_select))
		else $error("oscillator select moved on 11");

	// ======
	// Gain control and comparator
	a_gain_reset_hold: assert property (req.wr && req.addr == 10'h02b && req.wdata[4] |-> ##2 !gain_control_run)
		else $error("gain control runs while reset bit set");
	a_gain_release_run: assert property (req.wr && req.addr == 10'h02b && !req.wdata[4] |-> ##[1:3] gain_control_run)
		else $error("gain control not started after clear");
	a_cmp_held_zero: assert property (!gain_control_run && !$past(gain_control_run) |-> power_cmp_a == 2'b00)
		else $error("comparator output while gain held");
	a_cmp_wait_sample: assert property (gain_control_run && $past(gain_control_run) && !$past(avg_power_valid)
		&& !$past(req.wr) && !$past(req.wr, 2) |-> $stable(power_cmp_a))
		else $error("comparator moved without a sample");

	// Main scenarios
	c_read: cover property (req.rd);
	c_invalid: cover property (osc_select_invalid);
	c_low_two_bit: cover property (power_cmp_a == 2'b10);
	c_irq: cover property (irq);
endmodule : pwr_alarm_monitor

bind power_detect_alarm_pin_config pwr_alarm_monitor i_mon (.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
	.avg_power_valid(avg_power_valid), .pin_out(pin_out), .pin_oe(pin_oe), .osc_select(osc_select),
	.osc_select_invalid(osc_select_invalid), .gain_control_run(gain_control_run), .power_cmp_a(power_cmp_a),
	.irq(irq));

// File: pwr_alarm_pkg.sv
// Constants, field layouts and carriers for the power detector configuration slice.
// Assumes a plain single-cycle register port and one synchronous clock domain.
//
// Functional notes
// - Average power compared against 16-bit high and low thresholds, LSB 1/65536.
// - Each threshold held as two byte registers, low byte first, reset zero.
// - Format bit 0 gives 1-bit comparator output, 1 gives 2-bit output.
// - Gain-control held in reset while bit is 1, runs once it returns 0.
// - Direction bits 3..0 per pin: 0 input for oscillator select, 1 alarm output.
// - Bits 5..4 pick pin for select bit 1: 00 pin4,01 pin1,10 pin3,11 pin2.
// - Bits 1..0 pick pin for select bit 0 with the same encoding.
// - Select 00 oscillator 1, 01 oscillator 2, 10 oscillator 3; 11 not driven.
// - Per-pin 8-bit source select: codes 0-8 channel A, 9-17 channel B.
package pwr_alarm_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [9:0] ADDR_PWR_HIGH_LO = 10'h022;
	localparam logic [9:0] ADDR_PWR_HIGH_HI = 10'h023;
	localparam logic [9:0] ADDR_PWR_LOW_LO = 10'h024;
	localparam logic [9:0] ADDR_PWR_LOW_HI = 10'h025;
	localparam logic [9:0] ADDR_CMP_FORMAT = 10'h027;
	localparam logic [9:0] ADDR_GAIN_RESET = 10'h02b;
	localparam logic [9:0] ADDR_PIN1_SEL = 10'h032;
	localparam logic [9:0] ADDR_PIN2_SEL = 10'h033;
	localparam logic [9:0] ADDR_PIN3_SEL = 10'h034;
	localparam logic [9:0] ADDR_PIN4_SEL = 10'h035;
	localparam logic [9:0] ADDR_PIN_DIR = 10'h037;
	localparam logic [9:0] ADDR_OSC_ROUTE = 10'h038;
	localparam logic [9:0] ADDR_IRQ_STATUS = 10'h040;
	localparam logic [9:0] ADDR_IRQ_CLEAR = 10'h041;
	localparam logic [9:0] ADDR_IRQ_ENABLE = 10'h042;
	localparam logic [9:0] ADDR_STATE = 10'h043;

	// ==========================================================
	// Field positions, masks and reset values
	localparam int GAIN_RESET_BIT = 4;
	localparam int FORMAT_BIT = 0;
	localparam logic [7:0] DIR_MASK = 8'h0f;
	localparam logic [7:0] ROUTE_MASK = 8'h33;
	localparam int ROUTE1_LSB = 4;
	localparam int ROUTE0_LSB = 0;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] THRESH_RESET = 16'h0000;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// ==========================================================
	// Pin routing encodings (pin index 0..3 means pins 1..4)
	localparam logic [1:0] ROUTE_PIN4 = 2'b00;
	localparam logic [1:0] ROUTE_PIN1 = 2'b01;
	localparam logic [1:0] ROUTE_PIN3 = 2'b10;
	localparam logic [1:0] ROUTE_PIN2 = 2'b11;

	// Source select codes
	localparam logic [7:0] SRC_PER_CHANNEL = 8'h09;
	localparam logic [7:0] SRC_LAST = 8'h11;
	localparam logic [3:0] SRC_PWR0 = 4'h6;
	localparam logic [3:0] SRC_PWR1 = 4'h7;

	// ==========================================================
	// Oscillator choice and gain-control state
	typedef enum logic [1:0] {
		OSC_ONE = 2'b00,
		OSC_TWO = 2'b01,
		OSC_THREE = 2'b10,
		OSC_NONE = 2'b11
	} osc_sel_e;

	typedef enum logic [1:0] {
		GAIN_HELD = 2'b00,
		GAIN_RUN = 2'b01
	} gain_state_e;

	// Interrupt bits
	localparam int IRQ_HIGH = 0;
	localparam int IRQ_LOW = 1;
	localparam int IRQ_BAD_OSC = 2;
	localparam int IRQ_W = 3;

	// Register port carrier
	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	// One channel of alarm sources, codes 0..8
	typedef struct packed {
		logic fast_overrange_flag;
		logic [1:0] power_flag;
		logic block_peak_low_flag;
		logic block_peak_high_flag;
		logic [3:0] filter_peak;
	} chan_flags_s;

endpackage : pwr_alarm_pkg

// File: tb_top.sv
// Self-checking bench for the power detector configuration slice.
// Assumes a 50 MHz clock and the host model on the pins.
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	pwr_alarm_pkg::reg_req_s req = '0;
	logic [7:0] rdata;
	logic [15:0] avg_power = 16'h0000;
	logic avg_power_valid = 1'b0;
	pwr_alarm_pkg::chan_flags_s chan_a_flags = 9'h100;
	pwr_alarm_pkg::chan_flags_s chan_b_flags = 9'h100;
	logic [3:0] pin_in, pin_out, pin_oe, alarm_seen;
	logic [3:0] host_drive = 4'h0;
	logic [1:0] osc_select, power_cmp_a, prev, expv;
	logic osc_select_invalid, gain_control_run, irq;
	logic rd_seen = 1'b0;
	logic bad_seen = 1'b0;
	logic [7:0] exp_q[$];
	logic [15:0] th, tl;
	logic [3:0] p;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int seed = 32'h171a_7ada;
	logic [9:0] regs[12] = '{10'h022, 10'h023, 10'h024, 10'h025, 10'h027, 10'h02b, 10'h032, 10'h037,
		10'h038, 10'h040, 10'h042, 10'h030};
	logic [9:0] rsv[5] = '{10'h027, 10'h02b, 10'h037, 10'h038, 10'h030};
	logic [7:0] rmask[5] = '{8'h01, 8'h10, 8'h0f, 8'h33, 8'h00};

	power_detect_alarm_pin_config i_dut (.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
		.avg_power(avg_power), .avg_power_valid(avg_power_valid), .chan_a_flags(chan_a_flags),
		.chan_b_flags(chan_b_flags), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.osc_select(osc_select), .osc_select_invalid(osc_select_invalid),
		.gain_control_run(gain_control_run), .power_cmp_a(power_cmp_a), .irq(irq));
	osc_host_model i_host (.pin_out(pin_out), .pin_oe(pin_oe), .host_drive(host_drive), .pin_in(pin_in),
		.alarm_seen(alarm_seen));

	always #10 clk = ~clk;

	// ======
	// Tasks
	task automatic finish_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	task automatic compare(input string name, input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask : compare

	task automatic bus(input logic w, input logic r, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: w, rd: r};
	endtask : bus

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr

	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask : rd

	task automatic idle_wait(input int n);
		@(posedge clk);
		req <= '0;
		repeat (n) @(posedge clk);
		#1;
	endtask : idle_wait

	task automatic sample(input logic [15:0] v, input logic [1:0] e);
		@(posedge clk);
		avg_power <= v;
		avg_power_valid <= 1'b1;
		@(posedge clk);
		avg_power_valid <= 1'b0;
		#1;
		compare("power_cmp_a", 8'(power_cmp_a), 8'(e));
	endtask : sample

	function automatic logic pick(input logic [1:0] c, input logic [3:0] v);
		case (c)
			2'b00: return v[3];
			2'b01: return v[0];
			2'b10: return v[2];
			default: return v[1];
		endcase
	endfunction : pick

	// ======
	// Read result watcher and hang limit
	always @(posedge clk)
	begin
		rd_seen <= req.rd;
		cycles++;
		if (cycles == 4000)
		begin
			failures++;
			finish_test();
		end
	end
	always @(negedge clk)
		if (rd_seen)
			compare("rdata", rdata, exp_q.pop_front());

	// ======
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (regs[i]) rd(regs[i], 8'h00);
		th = {8'h40, 8'($random(seed))};
		tl = {8'h10, 8'($random(seed))};
		wr(10'h022, th[7:0]);
		wr(10'h023, th[15:8]);
		wr(10'h024, tl[7:0]);
		wr(10'h025, tl[15:8]);
		rd(10'h022, th[7:0]);
		rd(10'h023, th[15:8]);
		rd(10'h024, tl[7:0]);
		rd(10'h025, tl[15:8]);
		foreach (rsv[i])
		begin
			wr(rsv[i], rmask[i]);
			rd(rsv[i], rmask[i]);
		end
		idle_wait(3);
		compare("gain_control_run", 8'(gain_control_run), 8'h00);
		sample(th + 16'h0001, 2'b00);
		wr(10'h02b, 8'h00);
		wr(10'h042, 8'h03);
		idle_wait(3);
		compare("gain_control_run", 8'(gain_control_run), 8'h01);
		sample(th, 2'b00);
		sample(th + 16'h0001, 2'b01);
		compare("irq", 8'(irq), 8'h01);
		sample(tl, 2'b00);
		sample(tl - 16'h0001, 2'b10);
		rd(10'h040, 8'h03);
		wr(10'h041, 8'h03);
		rd(10'h040, 8'h00);
		idle_wait(2);
		compare("irq", 8'(irq), 8'h00);
		wr(10'h027, 8'h00);
		wr(10'h042, 8'h00);
		idle_wait(2);
		sample(tl - 16'h0001, 2'b00);
		sample(th + 16'h0001, 2'b01);
		compare("irq", 8'(irq), 8'h00);
		wr(10'h032, 8'h06);
		wr(10'h033, 8'h08);
		wr(10'h034, 8'h11);
		wr(10'h035, 8'h12);
		idle_wait(3);
		compare("alarm_seen", 8'(alarm_seen), 8'h07);
		compare("pin_oe", 8'(pin_oe), 8'h0f);
		wr(10'h037, 8'h05);
		idle_wait(2);
		compare("pin_out", 8'(pin_out), 8'h05);
		wr(10'h037, 8'h00);
		prev = 2'b00;
		for (int r = 0; r < 16; r++)
		begin
			wr(10'h038, {2'b00, 2'(r >> 2), 2'b00, 2'(r)});
			@(posedge clk);
			req <= '0;
			p = 4'($random(seed));
			host_drive <= p;
			repeat (3) @(posedge clk);
			#1;
			expv = {pick(2'(r >> 2), p), pick(2'(r), p)};
			if (expv != 2'b11)
				prev = expv;
			bad_seen = bad_seen | (expv == 2'b11);
			compare("osc_select_invalid", 8'(osc_select_invalid), 8'(expv == 2'b11));
			compare("osc_select", 8'(osc_select), 8'(prev));
		end
		// State and status words after the routing sweep
		rd(10'h043, {3'h0, expv == 2'b11, prev, 2'b01});
		rd(10'h040, {5'h00, bad_seen, 2'b11});
		idle_wait(2);
		finish_test();
	end
endmodule : tb_top
